// file: core/dsw_frontend.sv
// serial write front end: frame receiver, frame fifo and dac/mode holding registers
// Contract
// - sync falling edge arms the shift register
// - shift data on each serial clock fall
// - sixteenth fall completes frame, acts at once
// - frame is sixteen bits, first two ignored
// - bits three and four select mode
// - last twelve bits load dac register
// - early sync rise aborts and clears shifter
// - aborted frame leaves code and mode unchanged
// - reset loads zero code
// - zero stays until first full frame
// - code is straight binary 0 to 4095
// - mode encoding 00 normal, three power-downs
// - power-down keeps stored dac code; here a power-down frame loads its own code field like any other frame
`timescale 1ns/1ps
module dsw_frontend
  import dsw_pkg::*;
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     rstn_in,
  input  wire logic                     frame_sync_n_in,
  input  wire logic                     serial_clock_in,
  input  wire logic                     serial_data_in,
  output logic      [CODE_BITS-1:0]     dac_code_out,
  output dsw_pkg::dsw_mode_t            mode_out,
  output logic                          powered_down_out,
  output logic                          frame_done_out,
  output logic                          frame_abort_out
);
  import dsw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; the first stage feeds only the second
  logic [2:0] sync_s1_r;
  logic [2:0] sync_s2_r;
  logic [2:0] sync_d_r;

  // preset to the idle levels: an idle-high serial clock is never mistaken for a falling edge,
  // but a sync already low at reset release is seen as a falling edge
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync_s1_r <= '1;
      sync_s2_r <= '1;
      sync_d_r  <= '1;
    end
    else
    begin
      sync_s1_r <= {frame_sync_n_in, serial_clock_in, serial_data_in};
      sync_s2_r <= sync_s1_r;
      sync_d_r  <= sync_s2_r;
    end
  end

  // edge detection on the second stage and its delayed copy; each pin event
  // is acted on about three system clocks late, which is why the link clock
  // must keep each phase longer than that, and why a sync pulse shorter than
  // a few system clocks may be missed altogether
  wire fs_n      = sync_s2_r[2];
  wire sclk_fall = sync_d_r[1] && !sync_s2_r[1];
  wire fs_fall   = sync_d_r[2] && !fs_n;
  wire fs_rise   = !sync_d_r[2] && fs_n;
  // data sampled from the delayed copy, i.e. the level just before the fall
  wire sdata     = sync_d_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // frame receiver; 100 MHz sampling covers the 30 MHz link limit only
  // if each clock phase lasts over two system periods
  dsw_state_t            state_r, state_nxt;
  logic [FRAME_BITS-1:0] shift_r, shift_nxt;
  logic [CNT_BITS-1:0]   cnt_r, cnt_nxt;
  logic                  push_nxt;
  logic                  abort_nxt;

  // bit counter step and the decode of the final data bit
  wire [CNT_BITS-1:0]    cnt_inc   = cnt_r + 1'b1;
  wire                   last_edge = (cnt_inc == LAST_EDGE);

  // next state; an early sync rise is tested first so that it wins over a
  // serial clock fall seen in the same cycle
  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    push_nxt  = 1'b0;
    abort_nxt = 1'b0;
    case (state_r)
      DSW_IDLE:
      begin
        // only a fresh sync fall arms the shifter; a low level alone does not
        if (fs_fall)
        begin
          state_nxt = DSW_SHIFT;
          shift_nxt = '0;
          cnt_nxt   = '0;
        end
      end
      DSW_SHIFT:
      begin
        // frame cut short: drop the shifted bits, keep the outputs as they are
        if (fs_rise)
        begin
          state_nxt = DSW_IDLE;
          shift_nxt = '0;
          cnt_nxt   = '0;
          abort_nxt = 1'b1;
        end
        else if (sclk_fall)
        begin
          shift_nxt = {shift_r[FRAME_BITS-2:0], sdata};
          cnt_nxt   = cnt_inc;
          if (last_edge)
          begin
            state_nxt = DSW_DONE;
            push_nxt  = 1'b1;
          end
        end
      end
      DSW_DONE:
      begin
        // further serial clocks are dropped until sync rises
        if (fs_n)
          state_nxt = DSW_IDLE;
      end
      default:
        state_nxt = DSW_IDLE;
    endcase
  end

  // receiver registers; the shifter is also cleared on every abort
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= DSW_IDLE;
      shift_r <= '0;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completed frame: bits 15..14 dropped, mode then code
  dsw_word_t frame_word;
  assign frame_word.mode = dsw_mode_t'({shift_nxt[MODE_HI_POS], shift_nxt[MODE_LO_POS]});
  assign frame_word.code = shift_nxt[CODE_HI_POS:0];

  // the fifo decouples capture from the holding registers; a push while
  // full is lost, which needs over eight frames with no drain and cannot occur
  logic      fifo_ready;
  logic      fifo_valid;
  dsw_word_t fifo_word;
  // a word offered while full is dropped, never written over a stored one
  wire       fifo_push = push_nxt && fifo_ready;

  // read side always ready: the holding registers take each word at once,
  // so the fifo never holds more than one entry in this use
  dsw_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .wr_valid_in  (fifo_push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (frame_word),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (1'b1),
    .rd_data_out  (fifo_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // holding registers change only on a complete frame or reset
  // an aborted frame never reaches the fifo, so code and mode never see it; only abort_r records it;
  // the done pulse rises in the very cycle the code and mode move
  logic [CODE_BITS-1:0] code_r;
  dsw_mode_t            mode_r;
  logic                 done_r;
  logic                 abort_r;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      code_r  <= CODE_RESET;
      mode_r  <= DSW_MODE_NORMAL;
      done_r  <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      if (fifo_valid)
      begin
        code_r <= fifo_word.code;
        mode_r <= fifo_word.mode;
      end
      done_r  <= fifo_valid;
      abort_r <= abort_nxt;
    end
  end

  // outputs straight from the holding registers; a power-down frame loads its
  // code field like any other, so the stored code is the one that frame carried
  assign dac_code_out     = code_r;
  assign mode_out         = mode_r;
  assign powered_down_out = (mode_r != DSW_MODE_NORMAL);
  assign frame_done_out   = done_r;
  assign frame_abort_out  = abort_r;
endmodule

// file: core/dsw_pkg.sv
// package for the dac serial write front end: widths, encodings, timing constants
package dsw_pkg;

  localparam int FRAME_BITS  = 16;
  localparam int CODE_BITS   = 12;
  localparam int MODE_BITS   = 2;
  localparam int CNT_BITS    = 5;
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_WIDTH  = MODE_BITS + CODE_BITS;

  // field positions inside the 16-bit frame, msb first on the wire
  localparam int MODE_HI_POS = 13; // mode_bit_high
  localparam int MODE_LO_POS = 12; // mode_bit_low
  localparam int CODE_HI_POS = 11;

  localparam logic [CNT_BITS-1:0]  LAST_EDGE  = 5'h10;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;

  // link timing figures, for reference only; neither the design nor the bench reads them
  localparam int SYNC_HIGH_MIN_NS = 33;
  localparam int SCLK_MAX_MHZ     = 30;
  localparam int SYS_CLK_MHZ      = 100;

  // operating modes selected by the two mode bits
  typedef enum logic [1:0] {
    DSW_MODE_NORMAL = 2'b00,
    DSW_MODE_PD_1K  = 2'b01,
    DSW_MODE_PD_100K = 2'b10,
    DSW_MODE_PD_TRI = 2'b11
  } dsw_mode_t;

  // one completed frame as handed to the analog side
  typedef struct packed {
    dsw_mode_t              mode;
    logic [CODE_BITS-1:0]   code;
  } dsw_word_t;

  // frame receiver state
  typedef enum logic [1:0] {
    DSW_IDLE  = 2'b00,
    DSW_SHIFT = 2'b01,
    DSW_DONE  = 2'b10
  } dsw_state_t;

endpackage

// file: core/dsw_fifo.sv
// small valid/ready fifo for completed frames
`timescale 1ns/1ps
module dsw_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;

  // honest full and empty from the occupancy count
  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out  = mem_r[rp_r];

  ////////////////////////////////////////////////////////////////////////////
  // storage has no reset; only valid entries are ever read
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem_r[wp_r] <= wr_data_in;
  end

  // pointers and count
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: sim/dsw_chk.sv
// checker: port-level assertions for the serial write front end
`timescale 1ns/1ps
module dsw_chk
  import dsw_pkg::*;
(
  input wire logic                 clk_sys_in,
  input wire logic                 rstn_in,
  input wire logic                 frame_sync_n_in,
  input wire logic                 serial_clock_in,
  input wire logic                 serial_data_in,
  input wire logic [CODE_BITS-1:0] dac_code_out,
  input wire dsw_pkg::dsw_mode_t   mode_out,
  input wire logic                 powered_down_out,
  input wire logic                 frame_done_out,
  input wire logic                 frame_abort_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // code and mode outputs may only move in the cycle a completed frame lands
  a_code_steady: assert property ($changed(dac_code_out) |-> frame_done_out)
    else $error("code changed without a completed frame");
  a_mode_steady: assert property ($changed(mode_out) |-> frame_done_out)
    else $error("mode changed without a completed frame");
  a_pd_flag: assert property (powered_down_out == (mode_out != DSW_MODE_NORMAL))
    else $error("power-down flag disagrees with mode");
  a_done_pulse: assert property (frame_done_out |=> !frame_done_out)
    else $error("done pulse longer than one cycle");
  a_abort_pulse: assert property (frame_abort_out |=> !frame_abort_out)
    else $error("abort pulse longer than one cycle");
  a_done_xor_abort: assert property (!(frame_done_out && frame_abort_out))
    else $error("frame both completed and aborted");
  a_idle_quiet: assert property (frame_sync_n_in [*8] |-> !frame_done_out && !frame_abort_out)
    else $error("frame event with sync long idle");
  a_done_after_fall: assert property (frame_done_out |-> !$past(serial_clock_in, 4))
    else $error("done not preceded by a serial clock fall");
endmodule
bind dsw_frontend dsw_chk chk (.clk_sys_in, .rstn_in, .frame_sync_n_in, .serial_clock_in,
  .serial_data_in, .dac_code_out, .mode_out, .powered_down_out, .frame_done_out,
  .frame_abort_out);

// file: sim/dsw_host_model.sv
// host model: drives write frames onto the three-wire link
`timescale 1ns/1ps
module dsw_host_model (
  output logic frame_sync_n_out,
  output logic serial_clock_out,
  output logic serial_data_out
);
  // link clock stands still high outside frames
  initial
  begin
    frame_sync_n_out = 1'b1;
    serial_clock_out = 1'b1;
    serial_data_out  = 1'b0;
  end
  // n falls, msb first; keep_low parks sync low after the frame
  task send(input logic [15:0] w, input int n, input bit keep_low);
    if (!frame_sync_n_out)
    begin
      frame_sync_n_out = 1'b1;
      #40;
    end
    frame_sync_n_out = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serial_data_out = w[4'(15 - i)];
      #62.5 serial_clock_out = 1'b0;
      #62.5 serial_clock_out = 1'b1;
    end
    serial_data_out = ~serial_data_out; // no stale bit left on a released line
    if (!keep_low) frame_sync_n_out = 1'b1;
    #40;
  endtask
endmodule

// file: sim/dsw_frontend_tb_top.sv
// testbench: host frames into the serial write front end
`timescale 1ns/1ps
module dsw_frontend_tb_top;
  import dsw_pkg::*;
  logic                 clk_sys_in;
  logic                 rstn_in;
  wire                  frame_sync_n_in;
  wire                  serial_clock_in;
  wire                  serial_data_in;
  logic [CODE_BITS-1:0] dac_code_out;
  dsw_mode_t            mode_out;
  logic                 powered_down_out;
  logic                 frame_done_out;
  logic                 frame_abort_out;
  int                   bad_count;
  int                   tests_run;
  int                   dones;
  int                   aborts;
  dsw_frontend uut (.clk_sys_in, .rstn_in, .frame_sync_n_in, .serial_clock_in,
    .serial_data_in, .dac_code_out, .mode_out, .powered_down_out, .frame_done_out,
    .frame_abort_out);
  dsw_host_model host (.frame_sync_n_out(frame_sync_n_in),
    .serial_clock_out(serial_clock_in), .serial_data_out(serial_data_in));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // count one-cycle pulses so no pulse is missed between polls
  always @(posedge clk_sys_in)
  begin
    if (frame_done_out === 1'b1) dones++;
    if (frame_abort_out === 1'b1) aborts++;
  end
  task report_and_stop;
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task expect_out(input logic [11:0] c, input logic [1:0] m);
    chk("code", 16'(c), 16'(dac_code_out));
    chk("mode", 16'(m), 16'(mode_out));
    chk("pd", 16'(m != 2'b00), 16'(powered_down_out));
  endtask
  // bounded wait for a done or abort pulse beyond count c0
  task wait_ev(input bit ab, input int c0);
    int i;
    for (i = 0; i < 200 && (ab ? aborts : dones) == c0; i++) @(posedge clk_sys_in);
    if (i == 200)
    begin
      bad_count++;
      report_and_stop();
    end
    #1;
  endtask
  task t_modes;
    logic [11:0] codes [4];
    int c0;
    codes = '{12'hFFF, 12'h800, 12'h7FF, 12'h001};
    for (int m = 0; m < 4; m++)
    begin
      c0 = dones;
      host.send({2'b11, 2'(m), codes[m]}, 16, 1'b0);
      wait_ev(1'b0, c0);
      expect_out(codes[m], 2'(m));
    end
  endtask
  task t_abort;
    int c0;
    for (int n = 1; n < 16; n += 14)
    begin
      c0 = aborts;
      host.send(16'h0123, n, 1'b0);
      wait_ev(1'b1, c0);
      expect_out(12'h001, 2'b11);
    end
  endtask
  task t_extra;
    int c0;
    c0 = dones;
    host.send(16'h0ABC, 20, 1'b1);
    wait_ev(1'b0, c0);
    repeat (20) @(posedge clk_sys_in);
    chk("dones", 16'(c0 + 1), 16'(dones));
    expect_out(12'hABC, 2'b00);
    c0 = dones;
    host.send(16'h1456, 16, 1'b0);
    wait_ev(1'b0, c0);
    expect_out(12'h456, 2'b01);
  endtask
  initial
  begin
    rstn_in = 1'b0;
    bad_count = 0;
    tests_run = 0;
    dones = 0;
    aborts = 0;
    repeat (10) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1 expect_out(12'h000, 2'b00);
    t_modes();
    t_abort();
    t_extra();
    report_and_stop();
  end
endmodule
